// [trig_buf_pkg.sv]
// package for the trigger buffer sequencer: command codes, packet layout, sizes
// assumes: host commands arrive as four-word packets on a valid/ready stream
package trig_buf_pkg;
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned PKT_WORDS   = 4;
   localparam int unsigned NUM_BUFS    = 4;
   // servo capacities in packets
   localparam int unsigned CAP_B1      = 1024;
   localparam int unsigned CAP_B2_OWN  = 1000;
   localparam int unsigned CAP_B2_MAX  = 2000;
   localparam int unsigned CAP_B3      = 1024;
   localparam int unsigned CAP_B4      = 2048;
   localparam int unsigned FIFO_DEPTH  = 32;
   localparam logic [7:0]  OP_BEGIN_PRE = 8'hE1;
   localparam logic [7:0]  OP_END_PRE   = 8'hE2;
   localparam logic [7:0]  OP_DELIM     = 8'hE3;
   localparam logic [7:0]  OP_TRIG_MAN  = 8'hE4;
   localparam logic [7:0]  OP_TRIG_EN   = 8'hE5;

   typedef struct packed {
      logic [WORD_W-1:0] w3;
      logic [WORD_W-1:0] w2;
      logic [WORD_W-1:0] w1;
      logic [WORD_W-1:0] w0;   // w0[15:8] opcode, w0[1:0] or [3:0] argument
   } pkt_t;

   localparam int unsigned PKT_W = $bits(pkt_t);
endpackage

// [pkt_fifo.sv]
// holds the packet fifo for host and replayed packets, placed ahead of the execution stream
// assumes: single clock, drain side may stall
`timescale 1ns/1ps
module pkt_fifo #(
   parameter int unsigned WIDTH = 64,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_resetn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // handshake terms
   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem_q[rd_q];

   // storage
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [trigger_buffer_sequencer.sv]
// trigger buffer sequencer: four stored packet sequences replayed on trigger
// assumes: host packets arrive on a valid/ready stream, trigger pins are async
`timescale 1ns/1ps
// Functional notes
// - four buffers replay stored packets on enabled pin trigger or manual trigger
// - capacities 1024, 2048 for buffers one, three, four (servo sizes)
// - buffer two holds 1000 packets, or 2000 borrowing buffer three space; code always gives it CAP2 (2000 by default), overlapping buffer three
// - capacity is counted in four-word packets
// - contents persist across triggers; change only by overwrite or power-up
// - begin prestore, packets, end prestore; packets stored not executed
// - normal execution is suspended while prestore is active
// - each trigger replays up to next delimiter or buffer end
// - after the last sequence the next trigger replays the first one
// - pin inputs trigger only after trigger-input enable command
// - manual trigger works regardless of pin enable settings
// - buffers are first-in-first-out, replay in stored order
module trigger_buffer_sequencer #(
   parameter int unsigned CAP1 = trig_buf_pkg::CAP_B1,
   parameter int unsigned CAP2 = trig_buf_pkg::CAP_B2_MAX,
   parameter int unsigned CAP3 = trig_buf_pkg::CAP_B3,
   parameter int unsigned CAP4 = trig_buf_pkg::CAP_B4
) (
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_cmd_valid,
   output logic                           o_cmd_ready,
   input  wire trig_buf_pkg::pkt_t        i_cmd_pkt,
   input  wire logic [3:0]                i_trig_pin,
   output logic                           o_exe_valid,
   input  wire logic                      i_exe_ready,
   output trig_buf_pkg::pkt_t             o_exe_pkt,
   output logic                           o_prestore,
   output logic                           o_busy
);
   // memory layout: b1 | b2 own | b3 (borrowed by b2) | b4
   localparam int unsigned BASE2 = CAP1;
   localparam int unsigned BASE3 = CAP1 + trig_buf_pkg::CAP_B2_OWN;
   localparam int unsigned BASE4 = BASE3 + CAP3;
   localparam int unsigned TOTAL = BASE4 + CAP4;
   localparam int unsigned AW    = $clog2(TOTAL);
   localparam int unsigned PW    = trig_buf_pkg::PKT_W;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_STORE = 2'b01,
      ST_PLAY  = 2'b10
   } state_t;

   state_t             state_q;
   logic [PW-1:0]      mem_q [TOTAL];
   logic [AW-1:0]      len_q [4];      // stored packet count per buffer
   logic [AW-1:0]      pos_q [4];      // replay position per buffer
   logic [1:0]         sel_q;          // buffer being stored or replayed
   logic [3:0]         en_q;
   logic [3:0]         pend_q;
   logic [3:0]         pin_s1_q;
   logic [3:0]         pin_s2_q;
   logic [3:0]         pin_d_q;
   logic               fin_valid;
   logic               fin_ready;
   logic [PW-1:0]      fin_data;
   logic [PW-1:0]      rd_pkt;
   logic [7:0]         op;
   logic               take;
   logic               is_delim;
   logic               at_end;
   logic [3:0]         man_trig;
   logic [3:0]         pin_rise;
   logic               start_play;

   // base address of a buffer
   function automatic logic [AW-1:0] base_of(input logic [1:0] b);
      case (b)
         2'h0:    base_of = '0;
         2'h1:    base_of = AW'(BASE2);
         2'h2:    base_of = AW'(BASE3);
         default: base_of = AW'(BASE4);
      endcase
   endfunction

   // capacity of a buffer in four-word packets
   function automatic logic [AW-1:0] cap_of(input logic [1:0] b);
      case (b)
         2'h0:    cap_of = AW'(CAP1);
         2'h1:    cap_of = AW'(CAP2);
         2'h2:    cap_of = AW'(CAP3);
         default: cap_of = AW'(CAP4);
      endcase
   endfunction

   // lowest pending buffer is served first when triggers coincide
   function automatic logic [1:0] first_of(input logic [3:0] p);
      first_of = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (p[i]) first_of = 2'(i);
      end
   endfunction

   assign op      = i_cmd_pkt.w0[15:8];
   assign take    = i_cmd_valid && o_cmd_ready;
   // replay may only start on an idle cycle with no command taken
   assign start_play = (state_q == ST_IDLE) && !take && (pend_q != 4'h0);
   assign rd_pkt  = mem_q[base_of(sel_q) + pos_q[sel_q]];
   assign is_delim = (rd_pkt[15:8] == trig_buf_pkg::OP_DELIM);
   assign at_end  = (pos_q[sel_q] + 1'b1 >= len_q[sel_q]);
   // commands accepted unless replaying or, outside prestore, the fifo is full
   assign o_cmd_ready = (state_q != ST_PLAY) && (state_q == ST_STORE || fin_ready);
   assign o_prestore  = (state_q == ST_STORE);
   assign o_busy      = (state_q == ST_PLAY);

   // trigger pins: two-stage sync then rising edge
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_d_q  <= '0;
      end else begin
         pin_s1_q <= i_trig_pin;
         pin_s2_q <= pin_s1_q;
         pin_d_q  <= pin_s2_q;
      end
   end
   assign pin_rise = pin_s2_q & ~pin_d_q & en_q;
   assign man_trig = (take && state_q == ST_IDLE && op == trig_buf_pkg::OP_TRIG_MAN)
                     ? (4'h1 << i_cmd_pkt.w0[1:0]) : 4'h0;

   // trigger input enable mask
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         en_q <= '0;
      end else if (take && state_q == ST_IDLE && op == trig_buf_pkg::OP_TRIG_EN) begin
         en_q <= i_cmd_pkt.w0[3:0];
      end
   end

   // pending triggers; a new trigger wins over the clear on service
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pend_q <= '0;
      end else if (start_play) begin
         pend_q <= (pend_q & ~(4'h1 << first_of(pend_q))) | pin_rise | man_trig;
      end else begin
         pend_q <= pend_q | pin_rise | man_trig;
      end
   end

   // control state, selection and replay
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= ST_IDLE;
         sel_q   <= '0;
         for (int i = 0; i < 4; i++) begin
            len_q[i] <= '0;
            pos_q[i] <= '0;
         end
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take && op == trig_buf_pkg::OP_BEGIN_PRE) begin
                  state_q <= ST_STORE;
                  sel_q   <= i_cmd_pkt.w0[1:0];
                  len_q[i_cmd_pkt.w0[1:0]] <= '0;
                  pos_q[i_cmd_pkt.w0[1:0]] <= '0;
               end else if (start_play) begin
                  sel_q   <= first_of(pend_q);
                  state_q <= ST_PLAY;
               end
            end
            ST_STORE: begin
               if (take && op == trig_buf_pkg::OP_END_PRE) begin
                  state_q <= ST_IDLE;
               end else if (take && len_q[sel_q] < cap_of(sel_q)) begin
                  len_q[sel_q] <= len_q[sel_q] + 1'b1;
               end
            end
            ST_PLAY: begin
               if (len_q[sel_q] == '0) begin
                  state_q <= ST_IDLE;
               end else if (is_delim || fin_ready) begin
                  pos_q[sel_q] <= at_end ? '0 : pos_q[sel_q] + 1'b1;
                  if (is_delim || at_end) state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // packet storage, written only during prestore
   always_ff @(posedge i_ref_clk) begin
      if (state_q == ST_STORE && take && op != trig_buf_pkg::OP_END_PRE
          && len_q[sel_q] < cap_of(sel_q)) begin
         mem_q[base_of(sel_q) + len_q[sel_q]] <= i_cmd_pkt;
      end
   end

   // merge host packets and replayed packets into the execution fifo
   always_comb begin
      fin_valid = 1'b0;
      fin_data  = i_cmd_pkt;
      if (state_q == ST_PLAY) begin
         fin_valid = (len_q[sel_q] != '0) && !is_delim;
         fin_data  = rd_pkt;
      end else if (state_q == ST_IDLE && i_cmd_valid) begin
         fin_valid = (op != trig_buf_pkg::OP_BEGIN_PRE) && (op != trig_buf_pkg::OP_TRIG_MAN)
                     && (op != trig_buf_pkg::OP_TRIG_EN) && (op != trig_buf_pkg::OP_END_PRE)
                     && (op != trig_buf_pkg::OP_DELIM);
      end
   end

   pkt_fifo #(
      .WIDTH (PW),
      .DEPTH (trig_buf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_resetn    (i_resetn),
      .i_in_valid  (fin_valid),
      .o_in_ready  (fin_ready),
      .i_in_data   (fin_data),
      .o_out_valid (o_exe_valid),
      .i_out_ready (i_exe_ready),
      .o_out_data  (o_exe_pkt)
   );

   chk_prestore_no_exec: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      state_q == ST_STORE |-> !fin_valid) else $error("packet executed during prestore");
   chk_pin_needs_enable: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      (pin_s2_q & ~pin_d_q & ~en_q & ~man_trig) != 4'h0
      |=> (pend_q & ~$past(pend_q) & $past(pin_s2_q & ~pin_d_q & ~en_q & ~man_trig)) == 4'h0)
      else $error("disabled pin raised a trigger");
   chk_manual_sets: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      man_trig != 4'h0 |=> (pend_q & $past(man_trig)) != 4'h0) else $error("manual lost");
   chk_cap_limit: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      len_q[1] <= AW'(CAP2)) else $error("buffer two over capacity");
   // replay launch: idle on one edge, replaying on the next
   sequence play_start;
      state_q == ST_IDLE ##1 state_q == ST_PLAY;
   endsequence
   chk_play_order: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      play_start |-> !$past(pend_q[0]) || sel_q == 2'h0)
      else $error("lowest buffer not first");
   chk_wrap_pos: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      state_q == ST_PLAY && fin_ready && !is_delim && at_end && len_q[sel_q] != '0
      |=> pos_q[$past(sel_q)] == '0 && state_q == ST_IDLE) else $error("no wrap");
   chk_delim_stop: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      state_q == ST_PLAY && is_delim && len_q[sel_q] != '0 |=> state_q == ST_IDLE)
      else $error("replay ran past delimiter");
   chk_persist: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
      state_q != ST_STORE && !(take && op == trig_buf_pkg::OP_BEGIN_PRE)
      |=> len_q[$past(sel_q)] == $past(len_q[sel_q]))
      else $error("contents changed outside prestore");
endmodule

// [host_model.sv]
// host model: sends command packets and sinks the execution stream
// assumes: one clock, command ready is combinational in the design
`timescale 1ns/1ps
module host_model (
   input  wire logic               i_ref_clk,
   input  wire logic               i_hold,
   output logic                    o_cmd_valid,
   input  wire logic               i_cmd_ready,
   output trig_buf_pkg::pkt_t      o_cmd_pkt,
   input  wire logic               i_exe_valid,
   output logic                    o_exe_ready,
   input  wire trig_buf_pkg::pkt_t i_exe_pkt
);
   logic [15:0] rx_q[$];
   logic [1:0]  stall_q;
   initial begin
      o_cmd_valid = 1'h0;
      o_cmd_pkt   = '0;
      o_exe_ready = 1'h0;
      stall_q     = 2'h0;
   end
   // sink keeps tags, stalls one cycle in four or while held
   always @(posedge i_ref_clk) begin
      if (i_exe_valid && o_exe_ready) rx_q.push_back(i_exe_pkt.w1);
      stall_q <= stall_q + 2'h1;
      o_exe_ready <= #1 (stall_q != 2'h3) && !i_hold;
   end
   // hold packet until ready seen, leave valid up for back-to-back use
   task automatic send(input trig_buf_pkg::pkt_t p);
      o_cmd_valid = 1'h1;
      o_cmd_pkt   = p;
      do @(negedge i_ref_clk); while (i_cmd_ready !== 1'h1);
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic idle();
      o_cmd_valid = 1'h0;
   endtask
endmodule

// [testbench.sv]
// testbench for the trigger buffer sequencer, capacities shrunk to 8
// assumes: host_model drives commands, bench drives pins and reset
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [1:0] b;
      logic       pin;
      logic [4:0] en;
      logic [3:0] start;
      logic [3:0] cnt;
   } row_t;
   logic               clk = 1'h0;
   logic               resetn = 1'h0;
   logic               hold = 1'h0;
   logic [3:0]         pins = 4'h0;
   logic               cmd_valid, cmd_ready, exe_valid, exe_ready, prestore, busy;
   trig_buf_pkg::pkt_t cmd_pkt, exe_pkt;
   int                 miscompares = 0;
   int                 n_tests = 0;
   int                 cycles = 0;
   row_t rows[9] = '{'{2'h0, 1'h0, 5'h00, 4'h0, 4'h2}, '{2'h0, 1'h0, 5'h00, 4'h2, 4'h1},
      '{2'h0, 1'h1, 5'h00, 4'h0, 4'h0}, '{2'h0, 1'h1, 5'h1F, 4'h0, 4'h2},
      '{2'h1, 1'h0, 5'h00, 4'h0, 4'h3}, '{2'h1, 1'h0, 5'h00, 4'h0, 4'h3},
      '{2'h3, 1'h1, 5'h18, 4'h0, 4'h1}, '{2'h2, 1'h1, 5'h1B, 4'h0, 4'h0},
      '{2'h2, 1'h0, 5'h00, 4'h0, 4'h2}};
   logic [15:0] sim_tags[7] = '{16'h02, 16'h10, 16'h11, 16'h12, 16'h20, 16'h21, 16'h30};
   always #4 clk = ~clk;
   trigger_buffer_sequencer #(.CAP1(8), .CAP2(8), .CAP3(8), .CAP4(8)) dut_u (
      .i_ref_clk(clk), .i_resetn(resetn), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
      .i_cmd_pkt(cmd_pkt), .i_trig_pin(pins), .o_exe_valid(exe_valid),
      .i_exe_ready(exe_ready), .o_exe_pkt(exe_pkt), .o_prestore(prestore), .o_busy(busy));
   host_model host_u (
      .i_ref_clk(clk), .i_hold(hold), .o_cmd_valid(cmd_valid), .i_cmd_ready(cmd_ready),
      .o_cmd_pkt(cmd_pkt), .i_exe_valid(exe_valid), .o_exe_ready(exe_ready),
      .i_exe_pkt(exe_pkt));
   task automatic final_report();
      $display("compares %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         final_report();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic trig_buf_pkg::pkt_t mk(input logic [7:0] op, input logic [3:0] arg,
                                             input logic [15:0] tag);
      mk = {16'h0000, 16'h0000, tag, op, 4'h0, arg};
   endfunction
   task automatic cmd(input logic [7:0] op, input logic [3:0] arg);
      host_u.send(mk(op, arg, 16'h0000));
      host_u.idle();
      @(posedge clk);
      #1;
   endtask
   // bracketed load while no replay runs, delimiter after slot dpos
   task automatic store(input logic [1:0] b, input int n, input int dpos);
      cmd(trig_buf_pkg::OP_BEGIN_PRE, {2'h0, b});
      check({15'h0, prestore}, 16'h1);
      for (int k = 0; k < n; k++) begin
         host_u.send(mk(8'h10, 4'h0, {10'h0, b, k[3:0]}));
         if (k == dpos) host_u.send(mk(trig_buf_pkg::OP_DELIM, 4'h0, 16'h0000));
      end
      host_u.send(mk(trig_buf_pkg::OP_END_PRE, 4'h0, 16'h0000));
      host_u.idle();
      @(posedge clk);
      #1;
   endtask
   task automatic settle();
      int q;
      q = 0;
      for (int i = 0; i < 300 && q < 10; i++) begin
         @(posedge clk);
         #1;
         q = (busy || exe_valid) ? 0 : q + 1;
      end
   endtask
   // compare received tags with base+start.. and empty the sink
   task automatic expect_seq(input logic [15:0] base, input int start, input int cnt);
      settle();
      check(16'(host_u.rx_q.size()), 16'(cnt));
      for (int k = 0; k < cnt && k < host_u.rx_q.size(); k++)
         check(host_u.rx_q[k], base + 16'(start + k));
      host_u.rx_q.delete();
   endtask
   task automatic pulse(input logic [3:0] m);
      pins = m;
      repeat (4) @(posedge clk);
      #1;
      pins = 4'h0;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      resetn = 1'h1;
      check({12'h0, cmd_ready, exe_valid, prestore, busy}, 16'h8);
      store(2'h0, 3, 1);
      store(2'h1, 3, 15);
      store(2'h2, 2, 15);
      store(2'h3, 1, 15);
      expect_seq(16'h0, 0, 0);
      $display("prestore test done");
      foreach (rows[r]) begin
         if (rows[r].en[4]) cmd(trig_buf_pkg::OP_TRIG_EN, rows[r].en[3:0]);
         if (rows[r].pin) pulse(4'h1 << rows[r].b);
         else cmd(trig_buf_pkg::OP_TRIG_MAN, {2'h0, rows[r].b});
         expect_seq({10'h0, rows[r].b, 4'h0}, rows[r].start, rows[r].cnt);
         $display("row %0d done", r);
      end
      // all four pins at once
      cmd(trig_buf_pkg::OP_TRIG_EN, 4'hF);
      pulse(4'hF);
      settle();
      check(16'(host_u.rx_q.size()), 16'h7);
      for (int k = 0; k < 7 && k < host_u.rx_q.size(); k++) check(host_u.rx_q[k], sim_tags[k]);
      host_u.rx_q.delete();
      $display("simultaneous test done");
      // overload buffer four beyond capacity, old content overwritten
      store(2'h3, 10, 15);
      cmd(trig_buf_pkg::OP_TRIG_MAN, 4'h3);
      @(posedge clk);
      #1;
      check({15'h0, busy}, 16'h1);
      expect_seq(16'h30, 0, 8);
      $display("capacity test done");
      // fill the output fifo with the sink held, then drain
      hold = 1'h1;
      for (int k = 0; k < trig_buf_pkg::FIFO_DEPTH; k++) host_u.send(mk(8'h10, 4'h0, 16'h100 + 16'(k)));
      host_u.idle();
      repeat (2) @(posedge clk);
      #1;
      check({15'h0, cmd_ready}, 16'h0);
      hold = 1'h0;
      expect_seq(16'h100, 0, 32);
      $display("fifo test done");
      // power-up reset in mid-run clears stored sequences
      resetn = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'h1;
      check({12'h0, cmd_ready, exe_valid, prestore, busy}, 16'h8);
      cmd(trig_buf_pkg::OP_TRIG_MAN, 4'h1);
      expect_seq(16'h10, 0, 0);
      $display("reset test done");
      final_report();
   end
endmodule
